// file: dcpwm_pkg.sv
package dcpwm_pkg;

  // Bus geometry.
  localparam int DCPWM_AW = 18;
  localparam int DCPWM_DW = 32;
  localparam int DCPWM_NCH = 2;

  // Register indices; the byte address of each is four times its index.
  localparam logic [15:0] DCPWM_CTL_IDX [DCPWM_NCH] = '{16'hFFA0, 16'hFFA4};
  localparam logic [15:0] DCPWM_DUTY_IDX [DCPWM_NCH] = '{16'hFFA1, 16'hFFA5};
  localparam logic [15:0] DCPWM_CNT_IDX [DCPWM_NCH] = '{16'hFFA2, 16'hFFA6};
  localparam logic [15:0] DCPWM_PORT_DATA_IDX = 16'hFFA8;
  localparam logic [15:0] DCPWM_PORT_DIR_IDX = 16'hFFA9;
  localparam logic [15:0] DCPWM_PORT_PIN_IDX = 16'hFFAA;

  // Control register fields.
  localparam int DCPWM_CTL_RUN_BIT = 7;
  localparam int DCPWM_CTL_POL_BIT = 6;
  localparam int DCPWM_CTL_CKS_MSB = 2;
  localparam int DCPWM_CTL_CKS_LSB = 0;
  localparam logic [7:0] DCPWM_CTL_RESET = 8'h38;
  localparam logic [2:0] DCPWM_CTL_RSVD = 3'h7;

  // Counter and duty values.
  localparam logic [7:0] DCPWM_CNT_RESET = 8'h00;
  localparam logic [7:0] DCPWM_CNT_ONE = 8'h01;
  localparam logic [7:0] DCPWM_CNT_TOP = 8'hF9;
  localparam logic [7:0] DCPWM_DUTY_RESET = 8'hFF;
  localparam logic [7:0] DCPWM_DUTY_ZERO = 8'h00;
  localparam logic [7:0] DCPWM_DUTY_FULL = 8'hFA;

  // Prescaler taps: bit k of a free-running counter divides by 2^(k+1).
  localparam int DCPWM_PRESC_W = 12;
  localparam int DCPWM_TAP [8] = '{0, 2, 4, 6, 7, 9, 10, 11};

  // AXI responses.
  localparam logic [1:0] DCPWM_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCPWM_RESP_SLVERR = 2'h2;

endpackage

// file: dcpwm_prescaler.sv
`timescale 1ns/1ps
module dcpwm_prescaler
  import dcpwm_pkg::*;
#(
  parameter int PW = DCPWM_PRESC_W
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic init_i,
  output logic [PW-1:0] count_o
);

  logic [PW-1:0] count_reg;
  logic [PW-1:0] count_next;

  assign count_next = count_reg + {{(PW-1){1'b0}}, 1'b1};
  assign count_o = count_reg;

  // One divider feeds both channels; each channel picks its own tap.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || init_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// file: dcpwm_channel.sv
`timescale 1ns/1ps
module dcpwm_channel
  import dcpwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic init_i,
  input wire logic run_i,
  input wire logic polarity_select_i,
  input wire logic [2:0] prescale_select_i,
  input wire logic [DCPWM_PRESC_W-1:0] presc_i,
  input wire logic duty_we_i,
  input wire logic cnt_we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] duty_valid_o,
  output logic [7:0] pulse_counter_o,
  output logic pulse_o
);

  logic tap_d_reg;
  logic [7:0] cnt_reg;
  logic [7:0] duty_pend_reg;
  logic [7:0] duty_valid_reg;
  logic pulse_reg;

  wire tap_w = presc_i[DCPWM_TAP[prescale_select_i]]; // [RULE6]
  wire inc_w = tap_d_reg & ~tap_w & run_i; // [RULE7] [RULE3]
  wire wrap_w = inc_w & (cnt_reg == DCPWM_CNT_TOP); // [RULE17]
  wire [7:0] cnt_inc_w = wrap_w ? DCPWM_CNT_RESET : cnt_reg + DCPWM_CNT_ONE; // [RULE17]
  wire full_w = duty_valid_reg >= DCPWM_DUTY_FULL; // [RULE13]
  wire nonzero_w = duty_valid_reg != DCPWM_DUTY_ZERO; // [RULE13]
  // Active from the 00->01 step until the count passes the valid duty.
  wire active_w = full_w | (nonzero_w & (cnt_reg != DCPWM_CNT_RESET) & (cnt_reg <= duty_valid_reg)); // [RULE10] [RULE11]
  wire [7:0] pend_w = duty_we_i ? wdata_i : duty_pend_reg;

  assign duty_valid_o = duty_valid_reg; // [RULE14]
  assign pulse_counter_o = cnt_reg;
  assign pulse_o = pulse_reg;

  always_ff @(posedge mclk_i) begin
    tap_d_reg <= tap_w;
    if (!reset_n_i || init_i) begin
      cnt_reg <= DCPWM_CNT_RESET; // [RULE18]
    end else if (!run_i) begin
      cnt_reg <= DCPWM_CNT_RESET; // [RULE2]
    end else if (cnt_we_i) begin
      cnt_reg <= wdata_i;
    end else if (inc_w) begin
      cnt_reg <= cnt_inc_w;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || init_i) begin
      duty_pend_reg <= DCPWM_DUTY_RESET; // [RULE18]
      duty_valid_reg <= DCPWM_DUTY_RESET; // [RULE18]
    end else begin
      duty_pend_reg <= pend_w;
      if (!run_i && duty_we_i) begin
        duty_valid_reg <= wdata_i; // [RULE9]
      end else if (wrap_w) begin
        duty_valid_reg <= pend_w; // [RULE12]
      end
    end
  end

  // Polarity flips only the level, never the timing.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || init_i) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= run_i ? (active_w ^ polarity_select_i) : polarity_select_i; // [RULE4] [RULE2]
    end
  end

endmodule

// file: dcpwm_top.sv
`timescale 1ns/1ps
// How it works
// RULE1 - Control registers return to 0x38 on reset and while standby is asserted.
// RULE2 - Run bit low holds the counter at zero, stopped, with pulse output suppressed.
// RULE3 - Run bit, control bit 7, enables the output and counting on prescaler pulses.
// RULE4 - Polarity bit 6 inverts output levels only; timing stays identical.
// RULE5 - Control bits 5 to 3 ignore writes and always read as ones.
// RULE6 - Three-bit prescale field picks divide by 2,8,32,128,256,1024,2048,4096.
// RULE7 - Each counter step comes from a falling edge of the selected tap.
// RULE8 - Disabled channel pin follows the port data and direction registers.
// RULE9 - Duty writes while disabled take effect immediately.
// RULE10 - Running output goes active on the 00 to 01 step unless duty is zero.
// RULE11 - Running output goes inactive once the count passes the valid duty.
// RULE12 - Duty writes while running are applied after the F9 to 00 wrap.
// RULE13 - Duty zero means always inactive; FA to FF means always active.
// RULE14 - Duty reads return the currently valid value, not the pending one.
// RULE15 - Software sets prescale and polarity before setting the run bit.
// RULE16 - Software writes the counter only for test; results may surprise.
// RULE17 - Counter counts 00 up to F9 then restarts at 00, 250 steps.
// RULE18 - Duty resets to FF and counter to 00 on reset and standby.
// RULE19 - Two identical channel instances share only clock, prescaler and reset.
module dcpwm_top
  import dcpwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic standby_i,
  input wire logic [DCPWM_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DCPWM_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [DCPWM_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DCPWM_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic pulse_in_ch0_i,
  output logic pulse_out_ch0_o,
  output logic pulse_oe_ch0_o,
  input wire logic pulse_in_ch1_i,
  output logic pulse_out_ch1_o,
  output logic pulse_oe_ch1_o
);

  // Standby and pin levels come from outside the clock domain.
  logic sby_meta_reg;
  logic sby_sync_reg;
  logic [DCPWM_NCH-1:0] pin_meta_reg;
  logic [DCPWM_NCH-1:0] pin_sync_reg;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sby_meta_reg <= 1'b0;
      sby_sync_reg <= 1'b0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      sby_meta_reg <= standby_i;
      sby_sync_reg <= sby_meta_reg;
      pin_meta_reg <= {pulse_in_ch1_i, pulse_in_ch0_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire init_w = sby_sync_reg;

  // AXI4-Lite write side: address and data are held independently.
  logic awready_reg;
  logic wready_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [15:0] wr_idx_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire aw_take_w = s_axi_awvalid_i & awready_reg;
  wire w_take_w = s_axi_wvalid_i & wready_reg;
  wire wr_fire_w = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_go_w = wr_fire_w & wstrb0_reg;
  wire b_done_w = bvalid_reg & s_axi_bready_i;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      awready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      wr_idx_reg <= '0;
    end else if (aw_take_w) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b1;
      wr_idx_reg <= s_axi_awaddr_i[DCPWM_AW-1:2];
    end else if (wr_fire_w) begin
      aw_held_reg <= 1'b0;
    end else if (b_done_w) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wready_reg <= 1'b1;
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else if (w_take_w) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata_i[7:0];
      wstrb0_reg <= s_axi_wstrb_i[0];
    end else if (wr_fire_w) begin
      w_held_reg <= 1'b0;
    end else if (b_done_w) begin
      wready_reg <= 1'b1;
    end
  end

  // Per-channel decode, shared port decode.
  logic [DCPWM_NCH-1:0] wr_ctl_w;
  logic [DCPWM_NCH-1:0] wr_duty_w;
  logic [DCPWM_NCH-1:0] wr_cnt_w;
  logic [DCPWM_NCH-1:0] rd_hit_w;
  logic [7:0] rd_ch_data_w [DCPWM_NCH];
  logic [7:0] ctl_rd_w [DCPWM_NCH];
  logic [7:0] duty_rd_w [DCPWM_NCH];
  logic [7:0] cnt_rd_w [DCPWM_NCH];
  logic [DCPWM_NCH-1:0] pin_out_w;
  logic [DCPWM_NCH-1:0] pin_oe_w;
  logic [DCPWM_NCH-1:0] wr_ch_hit_w;

  wire wr_pdata_hit_w = wr_idx_reg == DCPWM_PORT_DATA_IDX;
  wire wr_pdir_hit_w = wr_idx_reg == DCPWM_PORT_DIR_IDX;
  wire wr_ppin_hit_w = wr_idx_reg == DCPWM_PORT_PIN_IDX;
  wire wr_mapped_w = (|wr_ch_hit_w) | wr_pdata_hit_w | wr_pdir_hit_w | wr_ppin_hit_w;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= DCPWM_RESP_OKAY;
    end else if (wr_fire_w) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped_w ? DCPWM_RESP_OKAY : DCPWM_RESP_SLVERR;
    end else if (b_done_w) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Port data and direction used while a channel is disabled.
  logic [DCPWM_NCH-1:0] port_data_reg;
  logic [DCPWM_NCH-1:0] port_dir_reg;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      port_data_reg <= '0;
      port_dir_reg <= '0;
    end else begin
      if (wr_go_w && wr_pdata_hit_w) begin
        port_data_reg <= wdata_reg[DCPWM_NCH-1:0];
      end
      if (wr_go_w && wr_pdir_hit_w) begin
        port_dir_reg <= wdata_reg[DCPWM_NCH-1:0];
      end
    end
  end

  // AXI4-Lite read side: data is latched at the address handshake.
  logic [15:0] rd_idx_w;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DCPWM_DW-1:0] rdata_reg;
  logic [7:0] rd_data_w;

  assign rd_idx_w = s_axi_araddr_i[DCPWM_AW-1:2];
  wire ar_take_w = s_axi_arvalid_i & arready_reg;
  wire r_done_w = rvalid_reg & s_axi_rready_i;
  wire rd_pdata_hit_w = rd_idx_w == DCPWM_PORT_DATA_IDX;
  wire rd_pdir_hit_w = rd_idx_w == DCPWM_PORT_DIR_IDX;
  wire rd_ppin_hit_w = rd_idx_w == DCPWM_PORT_PIN_IDX;
  wire rd_mapped_w = (|rd_hit_w) | rd_pdata_hit_w | rd_pdir_hit_w | rd_ppin_hit_w;

  always_comb begin
    rd_data_w = '0;
    for (int i = 0; i < DCPWM_NCH; i++) begin
      rd_data_w = rd_data_w | rd_ch_data_w[i];
    end
    if (rd_pdata_hit_w) begin
      rd_data_w = {{(8-DCPWM_NCH){1'b0}}, port_data_reg};
    end
    if (rd_pdir_hit_w) begin
      rd_data_w = {{(8-DCPWM_NCH){1'b0}}, port_dir_reg};
    end
    if (rd_ppin_hit_w) begin
      rd_data_w = {{(8-DCPWM_NCH){1'b0}}, pin_sync_reg};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= DCPWM_RESP_OKAY;
      rdata_reg <= '0;
    end else if (ar_take_w) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_mapped_w ? DCPWM_RESP_OKAY : DCPWM_RESP_SLVERR;
      rdata_reg <= {{(DCPWM_DW-8){1'b0}}, rd_data_w};
    end else if (r_done_w) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Shared prescaler.
  logic [DCPWM_PRESC_W-1:0] presc_w;

  dcpwm_prescaler #(
    .PW(DCPWM_PRESC_W)
  ) u_presc (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .init_i(init_w),
    .count_o(presc_w)
  );

  for (genvar c = 0; c < DCPWM_NCH; c++) begin : g_ch
    logic run_reg;
    logic pol_reg;
    logic [2:0] cks_reg;
    logic pulse_w;
    logic out_reg;
    logic oe_reg;

    assign wr_ctl_w[c] = wr_idx_reg == DCPWM_CTL_IDX[c];
    assign wr_duty_w[c] = wr_idx_reg == DCPWM_DUTY_IDX[c];
    assign wr_cnt_w[c] = wr_idx_reg == DCPWM_CNT_IDX[c];
    assign wr_ch_hit_w[c] = wr_ctl_w[c] | wr_duty_w[c] | wr_cnt_w[c];

    wire rd_ctl_w = rd_idx_w == DCPWM_CTL_IDX[c];
    wire rd_duty_w = rd_idx_w == DCPWM_DUTY_IDX[c];
    wire rd_cnt_w = rd_idx_w == DCPWM_CNT_IDX[c];
    assign rd_hit_w[c] = rd_ctl_w | rd_duty_w | rd_cnt_w;
    assign ctl_rd_w[c] = {run_reg, pol_reg, DCPWM_CTL_RSVD, cks_reg}; // [RULE5]
    assign rd_ch_data_w[c] = ({8{rd_ctl_w}} & ctl_rd_w[c])
                           | ({8{rd_duty_w}} & duty_rd_w[c]) // [RULE14]
                           | ({8{rd_cnt_w}} & cnt_rd_w[c]);

    always_ff @(posedge mclk_i) begin
      if (!reset_n_i || init_w) begin
        run_reg <= DCPWM_CTL_RESET[DCPWM_CTL_RUN_BIT]; // [RULE1]
        pol_reg <= DCPWM_CTL_RESET[DCPWM_CTL_POL_BIT]; // [RULE1]
        cks_reg <= DCPWM_CTL_RESET[DCPWM_CTL_CKS_MSB:DCPWM_CTL_CKS_LSB]; // [RULE1]
      end else if (wr_go_w && wr_ctl_w[c]) begin
        run_reg <= wdata_reg[DCPWM_CTL_RUN_BIT]; // [RULE3]
        pol_reg <= wdata_reg[DCPWM_CTL_POL_BIT]; // [RULE4]
        cks_reg <= wdata_reg[DCPWM_CTL_CKS_MSB:DCPWM_CTL_CKS_LSB]; // [RULE6]
      end
    end

    dcpwm_channel u_ch ( // [RULE19]
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .init_i(init_w),
      .run_i(run_reg),
      .polarity_select_i(pol_reg),
      .prescale_select_i(cks_reg),
      .presc_i(presc_w),
      .duty_we_i(wr_go_w & wr_duty_w[c]),
      .cnt_we_i(wr_go_w & wr_cnt_w[c]),
      .wdata_i(wdata_reg),
      .duty_valid_o(duty_rd_w[c]),
      .pulse_counter_o(cnt_rd_w[c]),
      .pulse_o(pulse_w)
    );

    // The pin is a port pin whenever the channel is not running.
    always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
        out_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else begin
        out_reg <= run_reg ? pulse_w : port_data_reg[c]; // [RULE8] [RULE3]
        oe_reg <= run_reg | port_dir_reg[c]; // [RULE8]
      end
    end

    assign pin_out_w[c] = out_reg;
    assign pin_oe_w[c] = oe_reg;
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign pulse_out_ch0_o = pin_out_w[0];
  assign pulse_oe_ch0_o = pin_oe_w[0];
  assign pulse_out_ch1_o = pin_out_w[1];
  assign pulse_oe_ch1_o = pin_oe_w[1];

endmodule

// file: dcpwm_checker.sv
`timescale 1ns/1ps
module dcpwm_checker
  import dcpwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [DCPWM_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [DCPWM_DW-1:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic pulse_out_ch0_o,
  input wire logic pulse_oe_ch0_o,
  input wire logic pulse_oe_ch1_o
);
  logic ctl_rd_reg;
  logic bad_rd_reg;
  wire logic [15:0] ar_idx = s_axi_araddr_i[17:2];
  wire logic ar_bad = !(ar_idx inside {16'hFFA0, 16'hFFA1, 16'hFFA2, 16'hFFA4, 16'hFFA5, 16'hFFA6,
                                       16'hFFA8, 16'hFFA9, 16'hFFAA});
  wire logic ar_ctl = (ar_idx == DCPWM_CTL_IDX[0]) || (ar_idx == DCPWM_CTL_IDX[1]);

  // Remembers what the read in flight addressed.
  always_ff @(posedge mclk_i) begin
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      ctl_rd_reg <= ar_ctl;
      bad_rd_reg <= ar_bad;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped or changed before bready");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped or changed before rready");
  b_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");
  r_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  r_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  ctl_fixed_a: assert property (
    s_axi_rvalid_o && ctl_rd_reg |-> s_axi_rdata_o[5:3] == DCPWM_CTL_RSVD)
    else $error("control reserved bits not read as ones");
  unmapped_rd_a: assert property (s_axi_rvalid_o && bad_rd_reg
    |-> s_axi_rresp_o == DCPWM_RESP_SLVERR && s_axi_rdata_o == '0) else $error("unmapped read not refused");
  reset_quiet_a: assert property (disable iff (1'b0)
    !reset_n_i |=> !pulse_oe_ch0_o && !pulse_oe_ch1_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("outputs active during reset");
  pulse_width_a: assert property (
    pulse_oe_ch0_o && $past(pulse_oe_ch0_o) && $past(pulse_oe_ch0_o, 2) && $changed(pulse_out_ch0_o)
    |=> $stable(pulse_out_ch0_o) || !pulse_oe_ch0_o) else $error("pulse level changed faster than the counter steps");
endmodule

bind dcpwm_top dcpwm_checker u_chk (.mclk_i, .reset_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pulse_out_ch0_o,
  .pulse_oe_ch0_o, .pulse_oe_ch1_o);

// file: dcpwm_load.sv
`timescale 1ns/1ps
module dcpwm_load (
  input wire logic mclk_i,
  input wire logic clr_i,
  input wire logic [1:0] out_i,
  input wire logic [1:0] oe_i,
  output logic [1:0] pin_o,
  output int high_cnt_o
);
  // A released pin is pulled down by the load.
  assign pin_o = out_i & oe_i;

  // Counts clocks with channel 0 high, so the bench can judge the duty.
  always @(posedge mclk_i) high_cnt_o <= clr_i ? 0 : high_cnt_o + int'(pin_o[0]);
endmodule

// file: dcpwm_tb_top.sv
`timescale 1ns/1ps
module dcpwm_tb_top
  import dcpwm_pkg::*;
;
  logic mclk_i = 0;
  logic reset_n_i = 0;
  logic standby = 0;
  // The master raises ready at random while rr is set; counter timing runs with rr clear.
  logic rdy = 1, rr = 1;
  logic clr = 0;
  logic [DCPWM_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, pout, poe, pin;
  logic [7:0] got, v;
  logic [34:0] note;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  int hcnt, e, a;
  int n_fail = 0, tests_run = 0, seed = 52382;
  int dv[8] = '{2, 8, 32, 128, 256, 1024, 2048, 4096};
  logic [7:0] dt[7] = '{8'h00, 8'h01, 8'h7D, 8'hF9, 8'hFA, 8'hFF, 8'h33};

  dcpwm_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .standby_i(standby),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(rdy), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rdy), .pulse_in_ch0_i(pin[0]), .pulse_out_ch0_o(pout[0]), .pulse_oe_ch0_o(poe[0]),
    .pulse_in_ch1_i(pin[1]), .pulse_out_ch1_o(pout[1]), .pulse_oe_ch1_o(poe[1]));
  dcpwm_load u_load (.mclk_i(mclk_i), .clr_i(clr), .out_i(pout), .oe_i(poe), .pin_o(pin), .high_cnt_o(hcnt));

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    tests_run++;
    if (ex !== sn) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = DCPWM_RESP_OKAY);
    int t;
    t = 0;
    bq.push_back(er);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge mclk_i);
      t++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!(bvalid && rdy) && t < 200);
    if (t >= 200) n_fail++;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] ed, input logic on = 1,
                    input logic [1:0] er = DCPWM_RESP_OKAY);
    int t;
    t = 0;
    rq.push_back({on, er, 24'h0, ed});
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    do begin
      @(posedge mclk_i);
      t++;
      if (arready) arvalid <= 0;
    end while (!(rvalid && rdy) && t < 200);
    got = rdata[7:0];
    if (t >= 200) n_fail++;
  endtask

  // Compares each write answer, and each read answer noted with on set, with the oldest expectation noted by the driver.
  always @(posedge mclk_i) begin
    if (bvalid && rdy) chk("bresp", bq.pop_front(), bresp);
    if (rvalid && rdy) begin
      note = rq.pop_front();
      if (note[34]) chk("rresp", note[33:32], rresp);
      if (note[34]) chk("rdata", note[31:0], rdata);
    end
  end

  // Ready, once high, is held until an answer is sampled; otherwise it is drawn again.
  always @(posedge mclk_i) begin
    if (!rdy || bvalid || rvalid) rdy <= !rr || 1'($random(seed));
  end

  initial begin
    repeat (90000) @(posedge mclk_i);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1;
    @(posedge mclk_i);
    for (int i = 0; i < 2; i++) begin
      rd(DCPWM_CTL_IDX[i], DCPWM_CTL_RESET);
      rd(DCPWM_DUTY_IDX[i], DCPWM_DUTY_RESET);
      rd(DCPWM_CNT_IDX[i], DCPWM_CNT_RESET);
    end
    wr(DCPWM_DUTY_IDX[1], 8'h40);
    rd(DCPWM_DUTY_IDX[1], 8'h40);
    v = $random(seed);
    wr(DCPWM_CTL_IDX[1], v & 8'hC7);
    rd(DCPWM_CTL_IDX[1], {v[7:6], 3'h7, v[2:0]});
    wr(16'hFFA3, 8'h55, DCPWM_RESP_SLVERR);
    rd(16'hFFA3, 8'h00, 1, DCPWM_RESP_SLVERR);
    for (int i = 0; i < 7; i++) begin
      v = $random(seed);
      wr(DCPWM_CTL_IDX[0], {1'b0, v[0], 6'h0});
      wr(DCPWM_DUTY_IDX[0], dt[i]);
      wr(DCPWM_CTL_IDX[0], {1'b1, v[0], 6'h0});
      repeat (600) @(posedge mclk_i);
      clr <= 1;
      @(posedge mclk_i);
      clr <= 0;
      repeat (501) @(posedge mclk_i);
      e = dt[i] == 8'h00 ? 0 : dt[i] >= DCPWM_DUTY_FULL ? 500 : 2 * dt[i];
      chk("pin_high", v[0] ? 500 - e : e, hcnt);
    end
    rr <= 0;
    for (int c = 0; c < 8; c++) begin
      wr(DCPWM_CTL_IDX[0], 8'(c));
      wr(DCPWM_CTL_IDX[0], 8'h80 | 8'(c));
      rd(DCPWM_CNT_IDX[0], 8'h00, 0);
      a = got;
      repeat (8 * dv[c] - 2) @(posedge mclk_i);
      rd(DCPWM_CNT_IDX[0], 8'h00, 0);
      chk("count_step", 8, (int'(got) - a + 250) % 250);
    end
    rr <= 1;
    wr(DCPWM_CTL_IDX[0], 8'h00);
    rd(DCPWM_CNT_IDX[0], 8'h00);
    wr(DCPWM_DUTY_IDX[0], 8'h10);
    wr(DCPWM_CTL_IDX[0], 8'h80);
    do rd(DCPWM_CNT_IDX[0], 8'h00, 0); while (got > 8'hC0);
    wr(DCPWM_DUTY_IDX[0], 8'h80);
    rd(DCPWM_DUTY_IDX[0], 8'h10);
    repeat (600) @(posedge mclk_i);
    rd(DCPWM_DUTY_IDX[0], 8'h80);
    standby <= 1;
    repeat (6) @(posedge mclk_i);
    standby <= 0;
    repeat (4) @(posedge mclk_i);
    rd(DCPWM_CTL_IDX[0], DCPWM_CTL_RESET);
    rd(DCPWM_DUTY_IDX[0], DCPWM_DUTY_RESET);
    rd(DCPWM_CNT_IDX[0], DCPWM_CNT_RESET);
    wr(DCPWM_PORT_DIR_IDX, 8'h01);
    wr(DCPWM_PORT_DATA_IDX, 8'h01);
    repeat (4) @(posedge mclk_i);
    chk("pin0", 1, pin[0]);
    rd(DCPWM_PORT_PIN_IDX, 8'h01);
    wr(DCPWM_PORT_DATA_IDX, 8'h00);
    repeat (4) @(posedge mclk_i);
    chk("pin0", 0, pin[0]);
    wr(DCPWM_PORT_DIR_IDX, 8'h00);
    repeat (4) @(posedge mclk_i);
    stop_test();
  end
endmodule
